/* File: common/pmt_cfg.svh */
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH

`define PMT_COUNT_RESET 8'h00
`define PMT_PERIOD_RESET 8'hff
`define PMT_COUNT_ONE 8'h01
`define PMT_PRE_ZERO 6'h00
`define PMT_PRE_ONE 6'h01
`define PMT_PRE_MAX_1 6'h00
`define PMT_PRE_MAX_4 6'h03
`define PMT_PRE_MAX_16 6'h0f
`define PMT_PRE_MAX_64 6'h3f
`define PMT_POST_ZERO 4'h0
`define PMT_POST_ONE 4'h1
`define PMT_CTRL_RESET 7'h00
`define PMT_CTRL_POST_HI 6
`define PMT_CTRL_POST_LO 3
`define PMT_CTRL_ON_BIT 2
`define PMT_CTRL_PRE_HI 1
`define PMT_CTRL_PRE_LO 0
`define PMT_INSTANCES 3

`endif

/* File: common/pmt_pkg.sv */
package pmt_pkg;

typedef enum logic [1:0]
{
    PMT_PRE_DIV1 = 2'b00,
    PMT_PRE_DIV4 = 2'b01,
    PMT_PRE_DIV16 = 2'b10,
    PMT_PRE_DIV64 = 2'b11
} pmt_prescale_t;

endpackage : pmt_pkg

/* File: common/pmt_cfg_if.sv */
`timescale 1ns/100ps
interface pmt_cfg_if;
    logic [7:0] period_reg;
    logic [3:0] postscale_select;
    logic [1:0] prescale_select;
    logic timer_on_bit;
    logic sleep;
    logic scaler_clear;
    logic count_write;
    logic [7:0] count_wdata;
    logic [7:0] count_reg;
    logic match;
    logic irq_set;

    modport ctrl (output period_reg, postscale_select, prescale_select, timer_on_bit,
                  output sleep, scaler_clear, count_write, count_wdata,
                  input count_reg, match, irq_set);
    modport core (input period_reg, postscale_select, prescale_select, timer_on_bit,
                  input sleep, scaler_clear, count_write, count_wdata,
                  output count_reg, match, irq_set);
endinterface : pmt_cfg_if

/* File: rtl/pmt_core.sv */
`timescale 1ns/100ps
`include "pmt_cfg.svh"
module pmt_core
    import pmt_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    pmt_cfg_if.core cfg
);
    logic [5:0] pre_cnt;
    logic [5:0] pre_max;
    logic [3:0] post_cnt;
    logic tick;
    logic run;

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    always_comb
    begin
        case (pmt_prescale_t'(cfg.prescale_select))
            PMT_PRE_DIV1: pre_max = `PMT_PRE_MAX_1;
            PMT_PRE_DIV4: pre_max = `PMT_PRE_MAX_4;
            PMT_PRE_DIV16: pre_max = `PMT_PRE_MAX_16;
            default: pre_max = `PMT_PRE_MAX_64;
        endcase
    end

    // Sleep stops the prescaler and counter ticks; without writes the count and period hold
    assign run = cfg.timer_on_bit && !cfg.sleep;
    assign tick = run && (pre_cnt == pre_max);

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in || cfg.scaler_clear)
            pre_cnt <= `PMT_PRE_ZERO;
        else if (run)
            pre_cnt <= (pre_cnt == pre_max) ? `PMT_PRE_ZERO : pre_cnt + `PMT_PRE_ONE;
    end

    // ----------------------------------------
    // Counter and comparator
    // ----------------------------------------
    assign cfg.match = (cfg.count_reg == cfg.period_reg);

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            cfg.count_reg <= `PMT_COUNT_RESET;
        else if (cfg.count_write)
            cfg.count_reg <= cfg.count_wdata;
        else if (tick && cfg.match)
            cfg.count_reg <= `PMT_COUNT_RESET;
        else if (tick)
            cfg.count_reg <= cfg.count_reg + `PMT_COUNT_ONE;
    end

    // ----------------------------------------
    // Postscaler
    // ----------------------------------------
    // Matches are counted once per prescaled tick so a held match counts once per tick
    assign cfg.irq_set = tick && cfg.match && (post_cnt == cfg.postscale_select);

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in || cfg.scaler_clear)
            post_cnt <= `PMT_POST_ZERO;
        else if (cfg.irq_set)
            post_cnt <= `PMT_POST_ZERO;
        else if (tick && cfg.match)
            post_cnt <= post_cnt + `PMT_POST_ONE;
    end
endmodule : pmt_core

/* File: rtl/pmt_timer.sv */
`timescale 1ns/100ps
`include "pmt_cfg.svh"
// Function
// - Up to three identical timer copies, each with own state and flag.
// - Timer clocked from instruction clock through its prescaler.
// - Counter starts at zero and advances once per prescaled edge.
// - Prescaler divides by one, four, sixteen or sixty-four.
// - Counter compared with period every cycle; equality is the match output.
// - After a match counter reloads zero and match feeds postscaler.
// - Counter and period are eight bits, readable and writable.
// - Reset clears counter and sets period to all ones.
// - Scaler counts clear on counter write, control write and reset.
// - Four-bit postscaler counts matches and sets latched interrupt flag.
// - Sixteen postscale ratios, one to sixteen matches per flag.
// - Interrupt request forwarded only when match enable is set.
// - Unscaled match goes to capture/compare units as PWM time base.
// - Only first instance offers match as serial port shift clock.
// - During sleep the timer stops and keeps counter and period.
module pmt_timer
    import pmt_pkg::*;
#(
    // Set only on the first of up to three copies; every copy keeps its own state
    parameter bit SPI_CLOCK_SOURCE = 1'b1
)
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic sleep_in,
    input wire logic count_wr_in,
    input wire logic [7:0] count_wdata_in,
    input wire logic period_wr_in,
    input wire logic [7:0] period_wdata_in,
    input wire logic control_wr_in,
    input wire logic [6:0] control_wdata_in,
    input wire logic irq_enable_wr_in,
    input wire logic irq_enable_wdata_in,
    input wire logic irq_flag_wr_in,
    input wire logic irq_flag_wdata_in,
    output logic [7:0] count_reg_out,
    output logic [7:0] period_reg_out,
    output logic [6:0] timer_control_reg_out,
    output logic match_irq_flag_out,
    output logic match_irq_enable_out,
    output logic irq_request_out,
    output logic ccp_time_base_out,
    output logic spi_shift_clock_out
);
    logic [7:0] period_reg;
    logic [6:0] timer_control_reg;
    logic match_irq_flag;
    logic match_irq_enable;

    pmt_cfg_if cfg ();

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            period_reg <= `PMT_PERIOD_RESET;
        else if (period_wr_in)
            period_reg <= period_wdata_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            timer_control_reg <= `PMT_CTRL_RESET;
        else if (control_wr_in)
            timer_control_reg <= control_wdata_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            match_irq_enable <= 1'b0;
        else if (irq_enable_wr_in)
            match_irq_enable <= irq_enable_wdata_in;
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            match_irq_flag <= 1'b0;
        else if (cfg.irq_set)
            match_irq_flag <= 1'b1;
        else if (irq_flag_wr_in)
            match_irq_flag <= irq_flag_wdata_in;
    end

    // ----------------------------------------
    // Core hookup
    // ----------------------------------------
    assign cfg.period_reg = period_reg;
    assign cfg.postscale_select = timer_control_reg[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO];
    assign cfg.prescale_select = timer_control_reg[`PMT_CTRL_PRE_HI:`PMT_CTRL_PRE_LO];
    assign cfg.timer_on_bit = timer_control_reg[`PMT_CTRL_ON_BIT];
    assign cfg.sleep = sleep_in;
    assign cfg.scaler_clear = count_wr_in || control_wr_in;
    assign cfg.count_write = count_wr_in;
    assign cfg.count_wdata = count_wdata_in;

    pmt_core u_core
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .cfg(cfg.core)
    );

    // ----------------------------------------
    // Outputs, all registered
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            ccp_time_base_out <= 1'b0;
            spi_shift_clock_out <= 1'b0;
            irq_request_out <= 1'b0;
        end
        else
        begin
            ccp_time_base_out <= cfg.match;
            spi_shift_clock_out <= SPI_CLOCK_SOURCE && cfg.match;
            irq_request_out <= match_irq_flag && match_irq_enable;
        end
    end

    // Register mirrors are one cycle behind the live state
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            count_reg_out <= `PMT_COUNT_RESET;
            period_reg_out <= `PMT_PERIOD_RESET;
            timer_control_reg_out <= `PMT_CTRL_RESET;
            match_irq_flag_out <= 1'b0;
            match_irq_enable_out <= 1'b0;
        end
        else
        begin
            count_reg_out <= cfg.count_reg;
            period_reg_out <= period_reg;
            timer_control_reg_out <= timer_control_reg;
            match_irq_flag_out <= match_irq_flag;
            match_irq_enable_out <= match_irq_enable;
        end
    end
endmodule : pmt_timer

/* File: sim/pmt_timer_props.sv */
`timescale 1ns/100ps
module pmt_timer_props
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic sleep_in,
    input wire logic count_wr_in,
    input wire logic period_wr_in,
    input wire logic [7:0] period_wdata_in,
    input wire logic irq_flag_wr_in,
    input wire logic [7:0] count_reg_out,
    input wire logic [7:0] period_reg_out,
    input wire logic match_irq_flag_out,
    input wire logic match_irq_enable_out,
    input wire logic irq_request_out,
    input wire logic ccp_time_base_out,
    input wire logic spi_shift_clock_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ----------------------------------------------------------------
    // Outputs trail internal state by one edge, so writes show two on
    // ----------------------------------------------------------------
    sequence s_per_lands;
        ##2 period_reg_out == $past(period_wdata_in, 2);
    endsequence
    property p_rst; $rose(nrst_in) |-> count_reg_out == 8'h00 && period_reg_out == 8'hff; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_per; period_wr_in |-> s_per_lands; endproperty
    a_per: assert property (p_per) else $error("period write lost");
    property p_match; ccp_time_base_out == (count_reg_out == period_reg_out); endproperty
    a_match: assert property (p_match) else $error("match output wrong");
    property p_spi; spi_shift_clock_out == ccp_time_base_out; endproperty
    a_spi: assert property (p_spi) else $error("shift clock differs");
    property p_zero; $changed(count_reg_out) && $past(ccp_time_base_out)
        && !$past(count_wr_in, 2) |-> count_reg_out == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("no reload after match");
    property p_inc; $changed(count_reg_out) && !$past(ccp_time_base_out)
        && !$past(count_wr_in, 2) |-> count_reg_out - $past(count_reg_out) == 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("count step wrong");
    property p_sleep; sleep_in && !count_wr_in |-> ##2 $stable(count_reg_out); endproperty
    a_sleep: assert property (p_sleep) else $error("count moved in sleep");
    property p_fall; $fell(match_irq_flag_out) |-> $past(irq_flag_wr_in, 2); endproperty
    a_fall: assert property (p_fall) else $error("flag dropped unasked");
    property p_irq; irq_request_out == (match_irq_flag_out && match_irq_enable_out); endproperty
    a_irq: assert property (p_irq) else $error("request not flag and enable");
endmodule : pmt_timer_props
bind pmt_timer pmt_timer_props i_props (.clk_in, .nrst_in, .sleep_in, .count_wr_in,
    .period_wr_in, .period_wdata_in, .irq_flag_wr_in, .count_reg_out, .period_reg_out,
    .match_irq_flag_out, .match_irq_enable_out, .irq_request_out, .ccp_time_base_out,
    .spi_shift_clock_out);

/* File: sim/pmt_timer_tb.sv */
`timescale 1ns/100ps
module pmt_timer_tb;
    logic clk_in = 1'b0, nrst_in = 1'b0, sleep_in = 1'b0, count_wr_in = 1'b0;
    logic period_wr_in = 1'b0, control_wr_in = 1'b0, irq_enable_wr_in = 1'b0;
    logic irq_flag_wr_in = 1'b0, irq_enable_wdata_in = 1'b0, irq_flag_wdata_in = 1'b0;
    logic [7:0] count_wdata_in = 8'h00, period_wdata_in = 8'h00;
    logic [6:0] control_wdata_in = 7'h00, timer_control_reg_out;
    logic [7:0] count_reg_out, period_reg_out;
    logic match_irq_flag_out, match_irq_enable_out, irq_request_out;
    logic ccp_time_base_out, spi_shift_clock_out;
    int failures = 0, num_checks = 0, cycles = 0;
    pmt_timer #(.SPI_CLOCK_SOURCE(1'b1)) i_dut (.clk_in, .nrst_in, .sleep_in, .count_wr_in,
        .count_wdata_in, .period_wr_in, .period_wdata_in, .control_wr_in, .control_wdata_in,
        .irq_enable_wr_in, .irq_enable_wdata_in, .irq_flag_wr_in, .irq_flag_wdata_in,
        .count_reg_out, .period_reg_out, .timer_control_reg_out, .match_irq_flag_out,
        .match_irq_enable_out, .irq_request_out, .ccp_time_base_out, .spi_shift_clock_out);
    always #5 clk_in = ~clk_in;
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            summarize();
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Kinds: 0 count, 1 period, 2 control, 3 enable, 4 flag; strobe drops at the next edge
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge clk_in);
        {count_wdata_in, period_wdata_in, control_wdata_in} <= {d, d, d[6:0]};
        {irq_enable_wdata_in, irq_flag_wdata_in} <= {d[0], d[0]};
        {count_wr_in, period_wr_in, control_wr_in, irq_enable_wr_in, irq_flag_wr_in} <= 5'h10 >> k;
        @(posedge clk_in);
        {count_wr_in, period_wr_in, control_wr_in, irq_enable_wr_in, irq_flag_wr_in} <= 5'h00;
    endtask : wr
    task automatic wflag(output int n);
        n = 0;
        while (match_irq_flag_out !== 1'b1 && n < 300)
        begin
            @(negedge clk_in);
            n++;
        end
    endtask : wflag
    // Caller aligns to a falling edge first, so back to back calls lose no cycle
    task automatic gap(output int n);
        logic [7:0] v;
        v = count_reg_out;
        n = 0;
        while (count_reg_out === v && n < 300)
        begin
            @(negedge clk_in);
            n++;
        end
    endtask : gap
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(negedge clk_in);
        cmp(count_reg_out, 8'h00);
        cmp(period_reg_out, 8'hff);
    endtask : t_reset
    task automatic t_walk;
        int n;
        wr(3, 8'h01);
        wr(1, 8'h02);
        wr(0, 8'h00);
        wr(2, 8'h04);
        wflag(n);
        cmp(8'(match_irq_flag_out), 8'h01);
        cmp(8'(irq_request_out), 8'h01);
        cmp(8'(timer_control_reg_out), 8'h04);
        wr(3, 8'h00);
        repeat (2) @(negedge clk_in);
        cmp(8'(irq_request_out), 8'h00);
        cmp(8'(match_irq_enable_out), 8'h00);
    endtask : t_walk
    task automatic t_pre;
        int n;
        wr(1, 8'hff);
        for (int c = 0; c < 4; c++)
        begin
            wr(2, {6'h01, c[1:0]});
            @(negedge clk_in);
            gap(n);
            gap(n);
            cmp(8'(n), 8'(1 << (2 * c)));
        end
        // Write lands mid-interval; a cleared prescaler gives a full 64 cycles next
        repeat (20) @(negedge clk_in);
        wr(0, 8'h10);
        @(negedge clk_in);
        gap(n);
        gap(n);
        cmp(8'(n), 8'h40);
    endtask : t_pre
    task automatic t_post;
        int n[2];
        wr(1, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            wr(2, 8'h00);
            wr(4, 8'h00);
            wr(0, 8'h00);
            wr(2, {1'b0, i[0] ? 4'h5 : 4'h0, 3'b100});
            wflag(n[i]);
        end
        cmp(8'(n[1] - n[0]), 8'h05);
        cmp(8'(ccp_time_base_out), 8'h01);
        cmp(8'(spi_shift_clock_out), 8'h01);
    endtask : t_post
    task automatic t_hold;
        logic [7:0] v;
        wr(1, 8'hff);
        wr(2, 8'h04);
        sleep_in <= 1'b1;
        repeat (3) @(negedge clk_in);
        v = count_reg_out;
        repeat (10) @(negedge clk_in);
        cmp(count_reg_out, v);
        @(posedge clk_in);
        sleep_in <= 1'b0;
        wr(2, 8'h00);
        repeat (3) @(negedge clk_in);
        v = count_reg_out;
        repeat (10) @(negedge clk_in);
        cmp(count_reg_out, v);
        wr(0, 8'h5a);
        repeat (2) @(negedge clk_in);
        cmp(count_reg_out, 8'h5a);
        wr(1, 8'h3c);
        repeat (2) @(negedge clk_in);
        cmp(period_reg_out, 8'h3c);
    endtask : t_hold
    initial
    begin
        t_reset();
        t_walk();
        t_pre();
        t_post();
        t_hold();
        t_reset();
        summarize();
    end
endmodule : pmt_timer_tb
